// ==== relio_consts.svh ====
// register offsets, field positions and timing counts of the relay i/o block
`ifndef RELIO_CONSTS_SVH
`define RELIO_CONSTS_SVH
`define RIO_CLK_NS 100
`define RIO_TICK_MS 10
`define RIO_TICK_CYC ((`RIO_TICK_MS * 1000000) / `RIO_CLK_NS)
`define RIO_FORCE_MIN 5
`define RIO_FORCE_TICKS ((`RIO_FORCE_MIN * 60 * 1000) / `RIO_TICK_MS)
`define RIO_PULSE_INF 14'd9999
`define RIO_DLY_MAX 13'd6000
`define RIO_CTRL 8'h00
`define RIO_OUT_CFG 8'h04
`define RIO_FORCE_VAL 8'h08
`define RIO_OUT_STAT 8'h0c
`define RIO_DIRECT 8'h10
`define RIO_DI_CFG 8'h14
`define RIO_DI_STAT 8'h18
`define RIO_IRQ_STAT 8'h1c
`define RIO_IRQ_MASK 8'h20
`define RIO_PULSE_BASE 8'h40
`define RIO_DELAY_BASE 8'h60
`define RIO_COUNT_BASE 8'h80
`define RIO_CTRL_FORCE 0
`define RIO_CTRL_RELEASE 1
`define RIO_CTRL_UNLOCK 2
`define RIO_OC_INV 8
`define RIO_DI_IND 8
`define RIO_DI_ON 16
`define RIO_DI_OFF 24
`define RIO_IRQ_OFF 6
`define RIO_IRQ_FORCE_TO 12
`define RIO_OUT_ALL 8'hff
`define RIO_OUT_MA 8'h9f
`endif

// ==== relio_pkg.sv ====
// shared types of the relay i/o block
package relio_pkg;
	typedef logic [7:0] relio_addr_t;
	typedef logic [31:0] relio_word_t;
	typedef enum logic [1:0] {
		RIO_FRC_OFF = 2'b01,
		RIO_FRC_ON = 2'b10
	} relio_force_e;
endpackage : relio_pkg

// ==== relio_di_chan.sv ====
// one contact input channel: sync, polarity, on/off delay, edge counter
`timescale 1ns/1ps
`default_nettype none
module relio_di_chan #(
	parameter int DLY_W = 13,
	parameter int CNT_W = 16
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_in,
	// contact pin and timebase
	input wire logic pin_in,
	input wire logic tick_in,
	// settings
	input wire logic invert_in,
	input wire logic [DLY_W-1:0] delay_in,
	input wire logic cnt_wr_in,
	input wire logic [CNT_W-1:0] cnt_wdata_in,
	// conditioned results
	output logic status_out,
	output logic act_edge_out,
	output logic inact_edge_out,
	output logic [CNT_W-1:0] count_out
);
	logic s1, s2, s3, filt, next_filt, target;
	logic next_status, next_act, next_inact;
	logic [DLY_W-1:0] dcnt, next_dcnt;
	logic [CNT_W-1:0] next_count;

	// s1 feeds only s2; a change counts once s2 and s3 agree
	always_comb begin
		next_filt = (s2 == s3) ? s3 : filt;
		target = filt ^ invert_in;
		next_status = status_out;
		next_dcnt = '0;
		if (target != status_out) begin
			if (dcnt >= delay_in) begin
				next_status = target;
			end else if (tick_in) begin
				next_dcnt = dcnt + DLY_W'(1);
			end else begin
				next_dcnt = dcnt;
			end
		end
		next_act = next_status & ~status_out;
		next_inact = ~next_status & status_out;
		next_count = count_out;
		if (cnt_wr_in) begin
			next_count = cnt_wdata_in;
		end else if (next_act) begin
			next_count = count_out + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			filt <= 1'b0;
			status_out <= 1'b0;
			dcnt <= '0;
			act_edge_out <= 1'b0;
			inact_edge_out <= 1'b0;
			count_out <= '0;
		end else begin
			s1 <= pin_in;
			s2 <= s1;
			s3 <= s2;
			filt <= next_filt;
			status_out <= next_status;
			dcnt <= next_dcnt;
			act_edge_out <= next_act;
			inact_edge_out <= next_inact;
			count_out <= next_count;
		end
	end

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (reset_in);

	property p_dly_hold;
		(target != status_out) && (dcnt < delay_in) |=> $stable(status_out);
	endproperty
	a_dly_hold: assert property (p_dly_hold) else $error("input changed before delay");

	property p_act_dir;
		act_edge_out |-> status_out && !$past(status_out);
	endproperty
	a_act_dir: assert property (p_act_dir) else $error("active edge wrong way");

	property p_cnt_inc;
		!cnt_wr_in ##1 act_edge_out |-> count_out == $past(count_out) + CNT_W'(1);
	endproperty
	a_cnt_inc: assert property (p_cnt_inc) else $error("edge counter missed");
endmodule : relio_di_chan
`default_nettype wire

// ==== relio_top.sv ====
// relay outputs with latch, invert, force and pulses; six conditioned inputs
`timescale 1ns/1ps
`default_nettype none
`include "relio_consts.svh"
//
// Operation
// - each relay output follows its selected signal, latched or not per output
// - per-output polarity bit inverts the value before the pin
// - relay status bits writable only while force flag set
// - one force flag; five-minute timer clears flag and forced outputs
// - alarm outputs hold remote pulse length 0.00 to 99.98 s
// - length 99.99 means endless; writing zero to direct control releases
// - with current-output option only first three alarm outputs exist
// - six contact inputs, each with a conditioned status bit
// - programmable 0 to 60 s delay on both input transitions
// - inversion setting selects active edge rising or falling
// - 16-bit active-edge counter per input, loadable by privileged write
// - indication setting gives one-shot pop-up request on active edge
// - active-edge event enable gates events on active edges
// - inactive-edge event enable gates events on inactive edges
// - conditioned input bits exported for routing, blocking and logic
// - latched output stays on after its signal drops
// - common release clears every latched output at once
module relio_top #(
	parameter bit MA_OPTION = 1'b0,
	parameter int TICK_CYCLES = `RIO_TICK_CYC,
	parameter int FORCE_TICKS = `RIO_FORCE_TICKS
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_in,
	// register port
	input wire relio_pkg::relio_addr_t reg_addr_in,
	input wire relio_pkg::relio_word_t reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output relio_pkg::relio_word_t reg_rdata_out,
	// selected matrix signals and latch release
	input wire logic [7:0] ctrl_sig_in,
	input wire logic release_in,
	// contact pins
	input wire logic [5:0] contact_input_channels_in,
	// relay drives
	output logic [1:0] trip_output_status_out,
	output logic [4:0] alarm_output_status_out,
	output logic service_status_output_out,
	// conditioned inputs and events
	output logic [5:0] di_status_out,
	output logic [5:0] di_on_event_out,
	output logic [5:0] di_off_event_out,
	output logic [5:0] indication_req_out,
	output logic irq_out
);
	import relio_pkg::*;

	localparam logic [7:0] OUT_EXIST = MA_OPTION ? `RIO_OUT_MA : `RIO_OUT_ALL;

	function automatic logic hit(input relio_addr_t a, input relio_addr_t base, input int idx);
		hit = (a == base + relio_addr_t'(idx * 4));
	endfunction : hit

	logic [16:0] tick_cnt, next_tick_cnt;
	logic tick;
	always_comb begin
		tick = (tick_cnt == 17'(TICK_CYCLES - 1));
		next_tick_cnt = tick ? 17'h0 : tick_cnt + 17'h1;
	end
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			tick_cnt <= 17'h0;
		end else begin
			tick_cnt <= next_tick_cnt;
		end
	end

	logic wr_ctrl, wr_direct, rel_evt, force_to;
	assign wr_ctrl = reg_wr_in && (reg_addr_in == `RIO_CTRL);
	assign wr_direct = reg_wr_in && (reg_addr_in == `RIO_DIRECT);
	assign rel_evt = release_in | (wr_ctrl & reg_wdata_in[`RIO_CTRL_RELEASE]);

	// force flag with its own timeout
	relio_force_e force_st, next_force_st;
	logic [14:0] force_cnt, next_force_cnt;
	always_comb begin
		next_force_st = force_st;
		next_force_cnt = force_cnt;
		force_to = 1'b0;
		case (force_st)
			RIO_FRC_OFF: begin
				if (wr_ctrl && reg_wdata_in[`RIO_CTRL_FORCE]) begin
					next_force_st = RIO_FRC_ON;
					next_force_cnt = 15'h0;
				end
			end
			RIO_FRC_ON: begin
				if (wr_ctrl && !reg_wdata_in[`RIO_CTRL_FORCE]) begin
					next_force_st = RIO_FRC_OFF;
				end else if (tick && force_cnt == 15'(FORCE_TICKS - 1)) begin
					next_force_st = RIO_FRC_OFF;
					force_to = 1'b1;
				end else if (tick) begin
					next_force_cnt = force_cnt + 15'h1;
				end
			end
			default: begin
				next_force_st = RIO_FRC_OFF;
			end
		endcase
	end
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			force_st <= RIO_FRC_OFF;
			force_cnt <= 15'h0;
		end else begin
			force_st <= next_force_st;
			force_cnt <= next_force_cnt;
		end
	end

	// configuration registers
	logic [7:0] latch_en, next_latch_en, invert, next_invert;
	logic [7:0] force_val, next_force_val;
	logic [5:0] di_inv, next_di_inv, di_ind, next_di_ind;
	logic [5:0] di_on_en, next_di_on_en, di_off_en, next_di_off_en;
	logic cnt_unlock, next_cnt_unlock;
	logic [12:0] irq_mask, next_irq_mask;
	logic [13:0] pulse_len [5];
	logic [13:0] next_pulse_len [5];
	logic [12:0] di_dly [6];
	logic [12:0] next_di_dly [6];
	always_comb begin
		next_latch_en = latch_en;
		next_invert = invert;
		next_force_val = force_val;
		next_di_inv = di_inv;
		next_di_ind = di_ind;
		next_di_on_en = di_on_en;
		next_di_off_en = di_off_en;
		next_cnt_unlock = cnt_unlock;
		next_irq_mask = irq_mask;
		next_pulse_len = pulse_len;
		next_di_dly = di_dly;
		if (reg_wr_in) begin
			if (reg_addr_in == `RIO_CTRL) begin
				next_cnt_unlock = reg_wdata_in[`RIO_CTRL_UNLOCK];
			end else if (reg_addr_in == `RIO_OUT_CFG) begin
				next_latch_en = reg_wdata_in[7:0] & OUT_EXIST;
				next_invert = reg_wdata_in[`RIO_OC_INV +: 8] & OUT_EXIST;
			end else if (reg_addr_in == `RIO_FORCE_VAL) begin
				if (force_st == RIO_FRC_ON) begin
					next_force_val = reg_wdata_in[7:0] & OUT_EXIST;
				end
			end else if (reg_addr_in == `RIO_DI_CFG) begin
				next_di_inv = reg_wdata_in[5:0];
				next_di_ind = reg_wdata_in[`RIO_DI_IND +: 6];
				next_di_on_en = reg_wdata_in[`RIO_DI_ON +: 6];
				next_di_off_en = reg_wdata_in[`RIO_DI_OFF +: 6];
			end else if (reg_addr_in == `RIO_IRQ_MASK) begin
				next_irq_mask = reg_wdata_in[12:0];
			end
			for (int i = 0; i < 5; i++) begin
				// length in ticks, clamped to endless code
				if (hit(reg_addr_in, `RIO_PULSE_BASE, i)) begin
					next_pulse_len[i] = (reg_wdata_in[13:0] > `RIO_PULSE_INF) ?
						`RIO_PULSE_INF : reg_wdata_in[13:0];
				end
			end
			for (int i = 0; i < 6; i++) begin
				if (hit(reg_addr_in, `RIO_DELAY_BASE, i)) begin
					next_di_dly[i] = (reg_wdata_in[12:0] > `RIO_DLY_MAX) ?
						`RIO_DLY_MAX : reg_wdata_in[12:0];
				end
			end
		end
		// forced values die with the flag
		if (next_force_st == RIO_FRC_OFF) begin
			next_force_val = 8'h00;
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			latch_en <= 8'h00;
			invert <= 8'h00;
			force_val <= 8'h00;
			di_inv <= 6'h00;
			di_ind <= 6'h00;
			di_on_en <= 6'h00;
			di_off_en <= 6'h00;
			cnt_unlock <= 1'b0;
			irq_mask <= 13'h0;
			for (int i = 0; i < 5; i++) begin
				pulse_len[i] <= 14'h0;
			end
			for (int i = 0; i < 6; i++) begin
				di_dly[i] <= 13'h0;
			end
		end else begin
			latch_en <= next_latch_en;
			invert <= next_invert;
			force_val <= next_force_val;
			di_inv <= next_di_inv;
			di_ind <= next_di_ind;
			di_on_en <= next_di_on_en;
			di_off_en <= next_di_off_en;
			cnt_unlock <= next_cnt_unlock;
			irq_mask <= next_irq_mask;
			pulse_len <= next_pulse_len;
			di_dly <= next_di_dly;
		end
	end

	// remote pulses on alarm outputs
	logic [13:0] pulse_cnt [5];
	logic [13:0] next_pulse_cnt [5];
	logic [4:0] pulse_inf, next_pulse_inf, pulse_act;
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			next_pulse_cnt[i] = pulse_cnt[i];
			next_pulse_inf[i] = pulse_inf[i];
			if (tick && pulse_cnt[i] != 14'h0) begin
				next_pulse_cnt[i] = pulse_cnt[i] - 14'h1;
			end
			if (wr_direct && OUT_EXIST[i + 2]) begin
				if (!reg_wdata_in[i]) begin
					next_pulse_cnt[i] = 14'h0;
					next_pulse_inf[i] = 1'b0;
				end else if (pulse_len[i] == `RIO_PULSE_INF) begin
					next_pulse_inf[i] = 1'b1;
				end else begin
					next_pulse_cnt[i] = pulse_len[i];
					next_pulse_inf[i] = 1'b0;
				end
			end
			pulse_act[i] = pulse_inf[i] | (pulse_cnt[i] != 14'h0);
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			pulse_inf <= 5'h00;
			for (int i = 0; i < 5; i++) begin
				pulse_cnt[i] <= 14'h0;
			end
		end else begin
			pulse_inf <= next_pulse_inf;
			pulse_cnt <= next_pulse_cnt;
		end
	end

	// output path: source, latch, force, polarity
	logic [7:0] src, latch_q, next_latch_q, stat, relay_q, next_relay_q;
	always_comb begin
		src = (ctrl_sig_in | {1'b0, pulse_act, 2'b00}) & OUT_EXIST;
		// latch holds; release wins in its own cycle, a still-live signal relatches on the next
		next_latch_q = rel_evt ? 8'h00 : (latch_q | src) & latch_en;
		stat = src | latch_q;
		if (force_st == RIO_FRC_ON) begin
			stat = force_val;
		end
		next_relay_q = (stat ^ invert) & OUT_EXIST;
	end
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			latch_q <= 8'h00;
			relay_q <= 8'h00;
		end else begin
			latch_q <= next_latch_q;
			relay_q <= next_relay_q;
		end
	end
	assign trip_output_status_out = relay_q[1:0];
	assign alarm_output_status_out = relay_q[6:2];
	assign service_status_output_out = relay_q[7];

	logic [5:0] di_stat, di_act, di_inact;
	logic [15:0] di_cnt [6];
	for (genvar g = 0; g < 6; g++) begin : g_di
		relio_di_chan #(
			.DLY_W(13),
			.CNT_W(16)
		) u_chan (
			.clk_sys_in(clk_sys_in),
			.reset_in(reset_in),
			.pin_in(contact_input_channels_in[g]),
			.tick_in(tick),
			.invert_in(di_inv[g]),
			.delay_in(di_dly[g]),
			.cnt_wr_in(reg_wr_in && cnt_unlock && hit(reg_addr_in, `RIO_COUNT_BASE, g)),
			.cnt_wdata_in(reg_wdata_in[15:0]),
			.status_out(di_stat[g]),
			.act_edge_out(di_act[g]),
			.inact_edge_out(di_inact[g]),
			.count_out(di_cnt[g])
		);
	end
	assign di_status_out = di_stat;
	assign indication_req_out = di_act & di_ind;
	assign di_on_event_out = di_act & di_on_en;
	assign di_off_event_out = di_inact & di_off_en;

	// sticky events, write one to clear; a new event beats the clear
	logic [12:0] irq_stat, next_irq_stat;
	always_comb begin
		next_irq_stat = irq_stat;
		if (reg_wr_in && reg_addr_in == `RIO_IRQ_STAT) begin
			next_irq_stat = irq_stat & ~reg_wdata_in[12:0];
		end
		next_irq_stat = next_irq_stat | {force_to, di_off_event_out, di_on_event_out};
	end
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			irq_stat <= 13'h0;
		end else begin
			irq_stat <= next_irq_stat;
		end
	end
	assign irq_out = |(irq_stat & irq_mask);

	// read data stand only in the cycle after the strobe; unmapped reads zero
	relio_word_t next_rdata;
	always_comb begin
		next_rdata = 32'h0;
		if (reg_rd_in) begin
			if (reg_addr_in == `RIO_CTRL) begin
				next_rdata[`RIO_CTRL_FORCE] = (force_st == RIO_FRC_ON);
				next_rdata[`RIO_CTRL_UNLOCK] = cnt_unlock;
			end else if (reg_addr_in == `RIO_OUT_CFG) begin
				next_rdata[15:0] = {invert, latch_en};
			end else if (reg_addr_in == `RIO_FORCE_VAL) begin
				next_rdata[7:0] = force_val;
			end else if (reg_addr_in == `RIO_OUT_STAT) begin
				next_rdata[7:0] = (relay_q ^ invert) & OUT_EXIST;
			end else if (reg_addr_in == `RIO_DIRECT) begin
				next_rdata[4:0] = pulse_act;
			end else if (reg_addr_in == `RIO_DI_CFG) begin
				next_rdata[5:0] = di_inv;
				next_rdata[`RIO_DI_IND +: 6] = di_ind;
				next_rdata[`RIO_DI_ON +: 6] = di_on_en;
				next_rdata[`RIO_DI_OFF +: 6] = di_off_en;
			end else if (reg_addr_in == `RIO_DI_STAT) begin
				next_rdata[5:0] = di_stat;
			end else if (reg_addr_in == `RIO_IRQ_STAT) begin
				next_rdata[12:0] = irq_stat;
			end else if (reg_addr_in == `RIO_IRQ_MASK) begin
				next_rdata[12:0] = irq_mask;
			end
			for (int i = 0; i < 5; i++) begin
				if (hit(reg_addr_in, `RIO_PULSE_BASE, i)) begin
					next_rdata[13:0] = pulse_len[i];
				end
			end
			for (int i = 0; i < 6; i++) begin
				if (hit(reg_addr_in, `RIO_DELAY_BASE, i)) begin
					next_rdata[12:0] = di_dly[i];
				end
				if (hit(reg_addr_in, `RIO_COUNT_BASE, i)) begin
					next_rdata[15:0] = di_cnt[i];
				end
			end
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			reg_rdata_out <= 32'h0;
		end else begin
			reg_rdata_out <= next_rdata;
		end
	end

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (reset_in);

	property p_frc_ignore;
		reg_wr_in && reg_addr_in == `RIO_FORCE_VAL && force_st == RIO_FRC_OFF
			|=> force_val == 8'h00;
	endproperty
	a_frc_ignore: assert property (p_frc_ignore) else $error("force write taken");

	property p_frc_to;
		force_st == RIO_FRC_ON && tick && !wr_ctrl && force_cnt == 15'(FORCE_TICKS - 1)
			|=> force_st == RIO_FRC_OFF && force_val == 8'h00 && irq_stat[`RIO_IRQ_FORCE_TO];
	endproperty
	a_frc_to: assert property (p_frc_to) else $error("force timeout missed");

	property p_latch_hold;
		!rel_evt && latch_q[0] && latch_en[0] && !ctrl_sig_in[0] && force_st == RIO_FRC_OFF
			|=> latch_q[0] && (force_st == RIO_FRC_ON || next_relay_q[0] == !invert[0]);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch dropped");

	property p_release;
		rel_evt |=> latch_q == 8'h00;
	endproperty
	a_release: assert property (p_release) else $error("release ignored");

	property p_pulse_load;
		wr_direct && reg_wdata_in[0] && OUT_EXIST[2] && pulse_len[0] != 14'h0
			&& pulse_len[0] != `RIO_PULSE_INF |=> pulse_cnt[0] == $past(pulse_len[0]);
	endproperty
	a_pulse_load: assert property (p_pulse_load) else $error("pulse not loaded");

	property p_pulse_rel;
		wr_direct && !reg_wdata_in[0] |=> !pulse_act[0] && !pulse_inf[0];
	endproperty
	a_pulse_rel: assert property (p_pulse_rel) else $error("pulse not released");

	property p_absent;
		MA_OPTION |-> alarm_output_status_out[4:3] == 2'b00;
	endproperty
	a_absent: assert property (p_absent) else $error("absent alarm driven");

	property p_on_gate;
		(di_on_event_out & ~di_on_en) == 6'h00 && (di_off_event_out & ~di_off_en) == 6'h00;
	endproperty
	a_on_gate: assert property (p_on_gate) else $error("event while disabled");
endmodule : relio_top
`default_nettype wire

// ==== relio_contacts.sv ====
// dry contact model that feeds the six contact input pins
`timescale 1ns/1ps
`default_nettype none
module relio_contacts (
	// clock
	input wire logic clk_sys_in,
	// commanded contact positions
	input wire logic [5:0] closed_in,
	// pins seen by the block
	output logic [5:0] pin_out
);
	// contacts are always wetted, so a pin never floats; it moves just after an edge
	initial pin_out = 6'h00;
	always @(posedge clk_sys_in) begin
		pin_out <= closed_in;
	end
endmodule : relio_contacts
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench of the relay i/o block
`timescale 1ns/1ps
`default_nettype none
`include "relio_consts.svh"
module tb_top;
	import relio_pkg::*;
	logic clk_sys_in, reset_in, reg_wr_in, reg_rd_in, release_in, svc, irq_out;
	relio_addr_t reg_addr_in;
	relio_word_t reg_wdata_in, reg_rdata_out, rd_data, rnd;
	logic [7:0] ctrl_sig_in, inv, relay_pins;
	logic [5:0] closed, pins, di_stat, on_ev, off_ev, ind_ev;
	logic [5:0] cond, nxt, inv_m, ind_m, on_m, off_m;
	logic [1:0] trip;
	logic [4:0] alarm, alarm_ma;
	int error_cnt, cmp_count, seed;
	int on_n[6], off_n[6], ind_n[6], e_on[6], e_off[6], e_ind[6], e_cnt[6];
	assign relay_pins = {svc, alarm, trip};

	relio_contacts i_relio_contacts (.clk_sys_in(clk_sys_in), .closed_in(closed), .pin_out(pins));
	relio_top #(.MA_OPTION(1'b0), .TICK_CYCLES(4), .FORCE_TICKS(5)) i_relio_top (
		.clk_sys_in(clk_sys_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .ctrl_sig_in(ctrl_sig_in), .release_in(release_in),
		.contact_input_channels_in(pins), .trip_output_status_out(trip),
		.alarm_output_status_out(alarm), .service_status_output_out(svc),
		.di_status_out(di_stat), .di_on_event_out(on_ev), .di_off_event_out(off_ev),
		.indication_req_out(ind_ev), .irq_out(irq_out));
	// the option build sees the same traffic; only its alarm drives are watched
	relio_top #(.MA_OPTION(1'b1), .TICK_CYCLES(4)) i_relio_top_ma (
		.clk_sys_in(clk_sys_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(), .ctrl_sig_in(ctrl_sig_in), .release_in(release_in),
		.contact_input_channels_in(pins), .trip_output_status_out(),
		.alarm_output_status_out(alarm_ma), .service_status_output_out(),
		.di_status_out(), .di_on_event_out(), .di_off_event_out(),
		.indication_req_out(), .irq_out());

	initial begin
		clk_sys_in = 1'b0;
		forever #50 clk_sys_in = ~clk_sys_in;
	end

	always @(posedge clk_sys_in) begin
		for (int k = 0; k < 6; k++) begin
			if (on_ev[k] === 1'b1) on_n[k]++;
			if (off_ev[k] === 1'b1) off_n[k]++;
			if (ind_ev[k] === 1'b1) ind_n[k]++;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask : cyc

	task automatic wr(input relio_addr_t a, input relio_word_t d);
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b0;
	endtask : wr

	task automatic rd(input relio_addr_t a);
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b0;
		@(negedge clk_sys_in);
		rd_data = reg_rdata_out;
	endtask : rd

	// move the contacts, let the longest delay run out, then update the model
	task automatic step(input logic [5:0] c);
		closed <= c;
		cyc(40);
		nxt = c ^ inv_m;
		for (int k = 0; k < 6; k++) begin
			if (nxt[k] && !cond[k]) begin
				e_cnt[k] = (e_cnt[k] + 1) % 65536;
				e_on[k] += int'(on_m[k]);
				e_ind[k] += int'(ind_m[k]);
			end
			if (!nxt[k] && cond[k]) e_off[k] += int'(off_m[k]);
		end
		cond = nxt;
		chk(di_stat, cond);
	endtask : step

	task automatic end_sim();
		$display("compares=%0d errors=%0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim

	initial begin
		#(30000 * 100);
		error_cnt++;
		end_sim();
	end

	initial begin
		seed = 95;
		reset_in = 1'b1;
		{reg_wr_in, reg_rd_in, release_in} = 3'b000;
		reg_addr_in = 8'h00;
		reg_wdata_in = 32'h0;
		ctrl_sig_in = 8'h00;
		closed = 6'h00;
		cyc(2);
		reset_in <= 1'b0;
		rd(`RIO_CTRL);
		chk(rd_data, 32'h0);
		for (int i = 0; i < 8; i++) begin
			rnd = $random(seed);
			inv = rnd[7:0];
			wr(`RIO_OUT_CFG, {16'h0, inv, 8'h00});
			rnd = $random(seed);
			ctrl_sig_in <= rnd[7:0];
			cyc(3);
			chk(relay_pins, ctrl_sig_in ^ inv);
			chk(alarm_ma[4:3], 2'b00);
		end
		wr(`RIO_OUT_CFG, 32'h0000_0001);
		ctrl_sig_in <= 8'h01;
		cyc(3);
		ctrl_sig_in <= 8'h00;
		cyc(3);
		chk(relay_pins, 8'h01);
		release_in <= 1'b1;
		cyc(1);
		release_in <= 1'b0;
		cyc(3);
		chk(relay_pins, 8'h00);
		wr(`RIO_OUT_CFG, 32'h0);
		wr(`RIO_FORCE_VAL, 32'h5a);
		rd(`RIO_FORCE_VAL);
		chk(rd_data, 32'h0);
		wr(`RIO_CTRL, 32'h1);
		wr(`RIO_FORCE_VAL, 32'ha5);
		cyc(2);
		chk(relay_pins, 8'ha5);
		rd(`RIO_OUT_STAT);
		chk(rd_data, 32'ha5);
		cyc(30);
		rd(`RIO_CTRL);
		chk(rd_data[0], 1'b0);
		chk(relay_pins, 8'h00);
		rd(`RIO_IRQ_STAT);
		chk(rd_data[12], 1'b1);
		wr(`RIO_IRQ_STAT, 32'h1fff);
		wr(`RIO_PULSE_BASE, 32'd3);
		wr(`RIO_PULSE_BASE + 8'h04, 32'd10000);
		rd(`RIO_PULSE_BASE + 8'h04);
		chk(rd_data, 32'd9999);
		// three ticks cover at least eight cycles whatever the prescaler phase
		wr(`RIO_DIRECT, 32'h01);
		cyc(10);
		chk(alarm, 5'h01);
		cyc(16);
		chk(alarm, 5'h00);
		wr(`RIO_DIRECT, 32'h02);
		cyc(60);
		chk(alarm, 5'h02);
		// the controlling side releases the endless pulse with a zero
		wr(`RIO_DIRECT, 32'h00);
		cyc(2);
		chk(alarm, 5'h00);
		inv_m = 6'h02;
		ind_m = 6'h15;
		on_m = 6'h1f;
		off_m = 6'h2f;
		wr(`RIO_DI_CFG, {2'b0, off_m, 2'b0, on_m, 2'b0, ind_m, 2'b0, inv_m});
		for (int k = 0; k < 6; k++) wr(`RIO_DELAY_BASE + 8'(4 * k), k);
		cyc(40);
		cond = inv_m;
		wr(`RIO_CTRL, 32'h4);
		for (int k = 0; k < 6; k++) begin
			e_cnt[k] = (k == 3) ? 65535 : 0;
			wr(`RIO_COUNT_BASE + 8'(4 * k), e_cnt[k]);
			e_on[k] = on_n[k];
			e_off[k] = off_n[k];
			e_ind[k] = ind_n[k];
		end
		wr(`RIO_CTRL, 32'h0);
		// locked again: this load must be ignored
		wr(`RIO_COUNT_BASE, 32'h1234);
		wr(`RIO_IRQ_STAT, 32'h1fff);
		wr(`RIO_IRQ_MASK, 32'h1);
		cyc(1);
		chk(irq_out, 1'b0);
		step(6'h09);
		chk(irq_out, 1'b1);
		for (int i = 0; i < 10; i++) begin
			rnd = $random(seed);
			step(rnd[5:0]);
		end
		// a blip shorter than the channel delay must leave no trace
		rnd[5:0] = closed;
		closed <= closed ^ 6'h04;
		cyc(3);
		step(rnd[5:0]);
		for (int k = 0; k < 6; k++) begin
			chk(on_n[k], e_on[k]);
			chk(off_n[k], e_off[k]);
			chk(ind_n[k], e_ind[k]);
			rd(`RIO_COUNT_BASE + 8'(4 * k));
			chk(rd_data, e_cnt[k]);
		end
		rd(`RIO_IRQ_STAT);
		chk(rd_data[0], 1'b1);
		wr(`RIO_IRQ_STAT, 32'h1fff);
		cyc(1);
		chk(irq_out, 1'b0);
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
